// ===== hdl/oms_top.sv
// Operation mode switcher for a motor drive with an AXI4-Lite slave.
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
// Function
// RULE_01 - Panel stop key stops the drive in every mode except panel.
// RULE_02 - Leaving external keeps external direction and last potentiometer speed.
// RULE_03 - Carried potentiometer speed is cleared by reset.
// RULE_04 - Host command enters link mode from external or panel.
// RULE_05 - Panel to external takes direction from external run inputs.
// RULE_06 - Entering external takes speed from the external speed input.
// RULE_07 - Panel to link keeps panel direction and speed.
// RULE_08 - Host command moves link mode to external.
// RULE_09 - Link to panel keeps link direction and speed.
// RULE_10 - Interlock works only with mode selection 7.
// RULE_11 - Interlock input falling forces external mode.
// RULE_12 - Interlock on permits entering panel mode.
// RULE_13 - Interlock off refuses entering panel mode.
// RULE_14 - Interlock on stops output in external run; off resumes it.
// RULE_15 - Interlock off while panel running goes external, follows external inputs.
// RULE_16 - Panel entry refused while a start input is on.
// RULE_17 - Forced external switch ignores start inputs.
// RULE_18 - Interlock off during external blocks panel entry after turning on.
// RULE_19 - Interlock and switchover inputs come from selectable terminals.
// RULE_20 - Switchover input works only with mode selection 8.
// RULE_21 - Switchover change applied only while stopped.
// RULE_22 - Switchover on selects external, off selects panel.
// RULE_23 - Reset selection 0 starts in external mode.
// RULE_24 - Mode is a register updated on a clock edge.
module oms_top
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [7:0] TERM_IN,
	input wire logic FWD_START_IN,
	input wire logic REV_START_IN,
	input wire logic [15:0] EXT_SPEED_IN,
	input wire logic PANEL_STOP_KEY,
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [1:0] MODE_OUT,
	output logic RUN_OUT,
	output logic [1:0] DIR_OUT,
	output logic [15:0] SPEED_OUT
);
	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	logic [7:0] term_meta_reg;
	logic [7:0] term_reg;
	logic [1:0] start_meta_reg;
	logic [1:0] start_reg;
	logic key_meta_reg;
	logic key_reg;
	logic [15:0] spd_meta_reg;
	logic [15:0] spd_reg;

	// Every terminal, start, key and speed pin passes two flops; only the second stage is read below.
	// The speed word is quasi-static, so a rare torn sample is tolerated.
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			term_meta_reg <= 8'h00;
			term_reg <= 8'h00;
			start_meta_reg <= 2'h0;
			start_reg <= 2'h0;
			key_meta_reg <= 1'b0;
			key_reg <= 1'b0;
			spd_meta_reg <= 16'h0000;
			spd_reg <= 16'h0000;
		end
		else
		begin
			term_meta_reg <= TERM_IN;
			term_reg <= term_meta_reg;
			start_meta_reg <= {FWD_START_IN, REV_START_IN};
			start_reg <= start_meta_reg;
			key_meta_reg <= PANEL_STOP_KEY;
			key_reg <= key_meta_reg;
			spd_meta_reg <= EXT_SPEED_IN;
			spd_reg <= spd_meta_reg;
		end
	end

	// ------------------------------------------------------------------
	// Registers and AXI4-Lite slave
	// ------------------------------------------------------------------
	logic [3:0] mode_sel_reg;
	logic stop_sel_reg;
	logic [2:0] ilk_sel_reg;
	logic [2:0] swo_sel_reg;
	logic [1:0] link_dir_reg;
	logic [15:0] panel_speed_reg;
	logic [15:0] link_speed_reg;
	logic [5:0] cmd_pulse_reg;
	logic aw_full_reg;
	logic w_full_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic do_write;

	// Write goes through once both address and data have been captured.
	assign do_write = aw_full_reg && w_full_reg && !S_AXI_BVALID;

	// Address and data channels are accepted independently, one deep each.
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= oms_pkg::BRESP_OKAY;
		end
		else
		begin
			S_AXI_AWREADY <= !aw_full_reg && !S_AXI_AWREADY;
			S_AXI_WREADY <= !w_full_reg && !S_AXI_WREADY;
			if (S_AXI_AWVALID && S_AXI_AWREADY)
			begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= S_AXI_AWADDR[7:0];
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY)
			begin
				w_full_reg <= 1'b1;
				w_data_reg <= S_AXI_WDATA;
				w_strb_reg <= S_AXI_WSTRB;
				S_AXI_WREADY <= 1'b0;
			end
			if (do_write)
			begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= (is_mapped(aw_addr_reg)) ?
					oms_pkg::BRESP_OKAY : oms_pkg::BRESP_SLVERR;
			end
			else if (S_AXI_BVALID && S_AXI_BREADY)
			begin
				S_AXI_BVALID <= 1'b0;
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
			end
		end
	end

	// Known word addresses; anything else answers SLVERR.
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == oms_pkg::ADDR_CTRL) || (a == oms_pkg::ADDR_CMD) ||
			(a == oms_pkg::ADDR_PANEL_SPEED) ||
			(a == oms_pkg::ADDR_LINK_SPEED) ||
			(a == oms_pkg::ADDR_STATUS) || (a == oms_pkg::ADDR_SPEED_OUT);
	endfunction

	// Configuration writes; only lanes 0 to 2 carry the fields used here.
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			mode_sel_reg <= oms_pkg::MODE_SEL_RESET;
			stop_sel_reg <= 1'b1;
			ilk_sel_reg <= 3'h0;
			swo_sel_reg <= 3'h1;
			link_dir_reg <= 2'h0;
			panel_speed_reg <= oms_pkg::SPEED_RESET;
			link_speed_reg <= oms_pkg::SPEED_RESET;
		end
		else if (do_write && aw_addr_reg == oms_pkg::ADDR_CTRL)
		begin
			if (w_strb_reg[0])
			begin
				mode_sel_reg <= w_data_reg[oms_pkg::CTRL_MODE_LSB +: 4];
				stop_sel_reg <= w_data_reg[oms_pkg::CTRL_STOPSEL_BIT];
			end
			if (w_strb_reg[1])
			begin
				ilk_sel_reg <= w_data_reg[oms_pkg::CTRL_ILK_SEL_LSB +: 3];
				swo_sel_reg <= w_data_reg[oms_pkg::CTRL_SWO_SEL_LSB +: 3];
			end
			if (w_strb_reg[2])
				link_dir_reg <= w_data_reg[oms_pkg::CTRL_LINKDIR_LSB +: 2];
		end
		else if (do_write && aw_addr_reg == oms_pkg::ADDR_PANEL_SPEED)
			panel_speed_reg <= w_data_reg[15:0];
		else if (do_write && aw_addr_reg == oms_pkg::ADDR_LINK_SPEED)
			link_speed_reg <= w_data_reg[15:0];
	end

	// Command register is write-only; each set bit of bits 0 to 5 makes a one-cycle pulse.
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			cmd_pulse_reg <= 6'h00;
		else if (do_write && aw_addr_reg == oms_pkg::ADDR_CMD && w_strb_reg[0])
			cmd_pulse_reg <= w_data_reg[5:0];
		else
			cmd_pulse_reg <= 6'h00;
	end

	// ------------------------------------------------------------------
	// Mode control
	// ------------------------------------------------------------------
	oms_pkg::oms_mode_t mode_reg;
	oms_pkg::oms_mode_t mode_next;
	oms_pkg::oms_dir_t dir_reg;
	oms_pkg::oms_dir_t ext_dir;
	logic [15:0] speed_reg;
	logic run_reg;
	logic ilk_in;
	logic swo_in;
	logic ilk_prev_reg;
	logic swo_prev_reg;
	logic ilk_fall;
	logic ilk_en;
	logic swo_en;
	logic panel_lock_reg;
	logic starts_on;
	logic stopped;
	logic panel_req;
	logic stop_req;
	logic link_dir_wr;
	logic link_spd_wr;
	logic panel_spd_wr;

	assign ilk_in = term_reg[ilk_sel_reg]; // [RULE_19]
	assign swo_in = term_reg[swo_sel_reg]; // [RULE_19]
	assign ilk_en = (mode_sel_reg == oms_pkg::MODE_SEL_INTERLOCK); // [RULE_10]
	assign swo_en = (mode_sel_reg == oms_pkg::MODE_SEL_SWITCHOVER); // [RULE_20]
	assign ilk_fall = ilk_en && ilk_prev_reg && !ilk_in; // [RULE_11]
	assign ext_dir = '{fwd: start_reg[1], rev: start_reg[0]};
	assign starts_on = start_reg[1] || start_reg[0];
	assign stopped = !run_reg;
	assign panel_req = cmd_pulse_reg[oms_pkg::CMD_TO_PANEL_BIT];
	// A host write moves the set point only in its own mode, so values
	// carried across a switch survive until someone sets new ones.
	assign link_dir_wr = do_write && aw_addr_reg == oms_pkg::ADDR_CTRL &&
		w_strb_reg[2];
	assign link_spd_wr = do_write &&
		aw_addr_reg == oms_pkg::ADDR_LINK_SPEED;
	assign panel_spd_wr = do_write &&
		aw_addr_reg == oms_pkg::ADDR_PANEL_SPEED;
	// The key counts as stop only outside panel mode and if enabled.
	assign stop_req = key_reg && stop_sel_reg &&
		(mode_reg != oms_pkg::OP_PANEL); // [RULE_01]

	// Interlock off latches a panel lockout until the mode leaves external.
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			ilk_prev_reg <= 1'b0;
			swo_prev_reg <= 1'b0;
			panel_lock_reg <= 1'b0;
		end
		else
		begin
			ilk_prev_reg <= ilk_in;
			swo_prev_reg <= swo_in;
			if (ilk_en && !ilk_in && mode_reg == oms_pkg::OP_EXT)
				panel_lock_reg <= 1'b1; // [RULE_18]
			else if (mode_reg != oms_pkg::OP_EXT || !ilk_en)
				panel_lock_reg <= 1'b0;
		end
	end

	// Next mode; the forced interlock change outranks every request.
	always_comb
	begin
		mode_next = mode_reg;
		if (ilk_fall)
			mode_next = oms_pkg::OP_EXT; // [RULE_11] [RULE_15] [RULE_17]
		else if (swo_en)
		begin
			if (stopped && swo_in != swo_prev_reg) // [RULE_21]
				mode_next = swo_in ? oms_pkg::OP_EXT : oms_pkg::OP_PANEL; // [RULE_22]
		end
		else if (cmd_pulse_reg[oms_pkg::CMD_TO_LINK_BIT] &&
			mode_reg != oms_pkg::OP_LINK)
			mode_next = oms_pkg::OP_LINK; // [RULE_04]
		else if (cmd_pulse_reg[oms_pkg::CMD_TO_EXT_BIT] &&
			mode_reg != oms_pkg::OP_EXT)
			mode_next = oms_pkg::OP_EXT; // [RULE_08]
		else if (panel_req && mode_reg != oms_pkg::OP_PANEL)
		begin
			if (ilk_en)
			begin
				if (ilk_in && !starts_on && !panel_lock_reg) // [RULE_12] [RULE_16]
					mode_next = oms_pkg::OP_PANEL; // [RULE_13] [RULE_18]
			end
			else
				mode_next = oms_pkg::OP_PANEL;
		end
	end

	// Mode state, direction and speed carried across each switch to panel or link.
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			mode_reg <= oms_pkg::OP_EXT; // [RULE_23]
			dir_reg <= '0;
			speed_reg <= oms_pkg::SPEED_RESET; // [RULE_03]
		end
		else
		begin
			mode_reg <= mode_next; // [RULE_24]
			case (mode_next)
				oms_pkg::OP_EXT:
				begin
					dir_reg <= ext_dir; // [RULE_05]
					speed_reg <= spd_reg; // [RULE_06]
				end
				oms_pkg::OP_PANEL:
				begin
					// Entering from external keeps the carried values.
					if (mode_reg == oms_pkg::OP_PANEL &&
						cmd_pulse_reg[oms_pkg::CMD_PANEL_RUN_BIT])
					begin
						dir_reg.fwd <= cmd_pulse_reg[oms_pkg::CMD_PANEL_FWD_BIT];
						dir_reg.rev <= !cmd_pulse_reg[oms_pkg::CMD_PANEL_FWD_BIT];
					end
					if (mode_reg == oms_pkg::OP_PANEL && panel_spd_wr)
						speed_reg <= w_data_reg[15:0];
				end // [RULE_02] [RULE_09]
				oms_pkg::OP_LINK:
				begin
					// Switch-in keeps previous direction and speed.
					if (mode_reg == oms_pkg::OP_LINK && link_dir_wr)
						dir_reg <= w_data_reg[oms_pkg::CTRL_LINKDIR_LSB +: 2];
					if (mode_reg == oms_pkg::OP_LINK && link_spd_wr)
						speed_reg <= w_data_reg[15:0];
				end // [RULE_02] [RULE_07]
				default:
					dir_reg <= dir_reg;
			endcase
		end
	end

	// Run flag: external follows starts, panel/link follow run and stop.
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			run_reg <= 1'b0;
		else if (stop_req)
			run_reg <= 1'b0; // [RULE_01]
		else if (mode_next == oms_pkg::OP_EXT)
			run_reg <= starts_on; // [RULE_15] [RULE_17]
		else if (cmd_pulse_reg[oms_pkg::CMD_PANEL_STOP_BIT])
			run_reg <= 1'b0;
		else if (cmd_pulse_reg[oms_pkg::CMD_PANEL_RUN_BIT])
			run_reg <= 1'b1;
		else if (mode_next == oms_pkg::OP_LINK &&
			mode_reg == oms_pkg::OP_LINK && link_dir_wr)
			run_reg <= (w_data_reg[oms_pkg::CTRL_LINKDIR_LSB +: 2] != 2'h0);
	end

	// Outputs; interlock on during external run gates the drive off.
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			MODE_OUT <= 2'h0;
			RUN_OUT <= 1'b0;
			DIR_OUT <= 2'h0;
			SPEED_OUT <= 16'h0000;
		end
		else
		begin
			MODE_OUT <= mode_reg[1:0];
			RUN_OUT <= run_reg && !(ilk_en && ilk_in &&
				mode_reg == oms_pkg::OP_EXT); // [RULE_14]
			DIR_OUT <= dir_reg;
			SPEED_OUT <= speed_reg;
		end
	end

	// ------------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------------
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= oms_pkg::BRESP_OKAY;
		end
		else if (S_AXI_RVALID)
		begin
			if (S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
		else if (S_AXI_ARVALID && S_AXI_ARREADY)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b1;
			S_AXI_RRESP <= is_mapped(S_AXI_ARADDR[7:0]) ?
				oms_pkg::BRESP_OKAY : oms_pkg::BRESP_SLVERR;
			case (S_AXI_ARADDR[7:0])
				oms_pkg::ADDR_CTRL:
					S_AXI_RDATA <= {14'h0000, link_dir_reg, 1'b0, swo_sel_reg,
						1'b0, ilk_sel_reg, 3'h0, stop_sel_reg, mode_sel_reg};
				oms_pkg::ADDR_PANEL_SPEED:
					S_AXI_RDATA <= {16'h0000, panel_speed_reg};
				oms_pkg::ADDR_LINK_SPEED:
					S_AXI_RDATA <= {16'h0000, link_speed_reg};
				oms_pkg::ADDR_STATUS:
					S_AXI_RDATA <= {24'h000000, panel_lock_reg, swo_in, ilk_in,
						run_reg, dir_reg, mode_reg[1:0]};
				oms_pkg::ADDR_SPEED_OUT:
					S_AXI_RDATA <= {16'h0000, speed_reg};
				default:
					S_AXI_RDATA <= 32'h00000000;
			endcase
		end
		else
			S_AXI_ARREADY <= !S_AXI_ARREADY;
	end
endmodule

// ===== hdl/oms_pkg.sv
// Package with constants, modes and register layout of the mode switcher.
package oms_pkg;
	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CMD = 8'h04;
	localparam logic [7:0] ADDR_PANEL_SPEED = 8'h08;
	localparam logic [7:0] ADDR_LINK_SPEED = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_SPEED_OUT = 8'h14;
	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_STOPSEL_BIT = 4;
	localparam int CTRL_ILK_SEL_LSB = 8;
	localparam int CTRL_SWO_SEL_LSB = 12;
	localparam int CTRL_LINKDIR_LSB = 16;
	localparam int CMD_TO_LINK_BIT = 0;
	localparam int CMD_TO_EXT_BIT = 1;
	localparam int CMD_TO_PANEL_BIT = 2;
	localparam int CMD_PANEL_RUN_BIT = 3;
	localparam int CMD_PANEL_STOP_BIT = 4;
	localparam int CMD_PANEL_FWD_BIT = 5;
	// ------------------------------------------------------------------
	// Reset values, mode selection codes, response codes and terminal count
	// ------------------------------------------------------------------
	localparam logic [3:0] MODE_SEL_RESET = 4'h0;
	localparam logic [3:0] MODE_SEL_INTERLOCK = 4'h7;
	localparam logic [3:0] MODE_SEL_SWITCHOVER = 4'h8;
	localparam logic [15:0] SPEED_RESET = 16'h0000;
	localparam logic [1:0] BRESP_OKAY = 2'h0;
	localparam logic [1:0] BRESP_SLVERR = 2'h2;
	localparam int TERM_COUNT = 8;

	typedef enum {OP_EXT, OP_PANEL, OP_LINK} oms_mode_t;

	// Direction pair: forward and reverse run requests.
	typedef struct packed {
		logic fwd;
		logic rev;
	} oms_dir_t;
endpackage

// ===== testbench/oms_top_chk.sv
// Checker that watches the ports of the operation mode switcher.
`timescale 1ns/1ns
module oms_top_chk
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic PANEL_STOP_KEY,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [1:0] MODE_OUT,
	input wire logic RUN_OUT,
	input wire logic [1:0] DIR_OUT,
	input wire logic [15:0] SPEED_OUT
);
	logic [3:0] aw_age_reg;

	// Cycles since the last accepted write address, saturating at 15.
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			aw_age_reg <= 4'hF;
		else if (S_AXI_AWVALID && S_AXI_AWREADY)
			aw_age_reg <= 4'h0;
		else if (aw_age_reg != 4'hF)
			aw_age_reg <= aw_age_reg + 4'h1;
	end

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	chk_mode_legal: assert property (MODE_OUT != 2'h3)
		else $error("mode output holds an unused code");
	chk_link_cause: assert property (MODE_OUT == 2'h2 &&
		$past(MODE_OUT) != 2'h2 |-> aw_age_reg < 4'hC)
		else $error("link mode entered without a host write");
	chk_run_dir: assert property (RUN_OUT |-> DIR_OUT != 2'h0)
		else $error("drive runs with no direction");
	// The key needs its synchroniser and output stage before it bites.
	chk_stop_key: assert property (
		(PANEL_STOP_KEY && MODE_OUT != 2'h1) [*6] |-> !RUN_OUT)
		else $error("stop key ignored outside panel mode");
	chk_reset_clear: assert property (disable iff (1'b0)
		!RESETN |-> MODE_OUT == 2'h0 && !RUN_OUT && SPEED_OUT == 16'h0)
		else $error("outputs not cleared by reset");
	chk_rvalid_next: assert property (
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	chk_bvalid_drop: assert property (
		S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
		else $error("write response repeated");
	chk_rvalid_drop: assert property (
		S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
		else $error("read response repeated");

	cov_link: cover property (MODE_OUT == 2'h2);
	cov_ext_run: cover property (RUN_OUT && MODE_OUT == 2'h0);
	cov_panel: cover property (MODE_OUT == 2'h1);
endmodule

// ===== testbench/oms_far_end.sv
// Far-side model: terminal block, start switches, speed pot and stop key.
`timescale 1ns/1ns
module oms_far_end
(
	input wire logic clk,
	input wire logic want_fwd,
	input wire logic want_rev,
	input wire logic want_key,
	input wire logic [7:0] want_term,
	input wire logic [15:0] want_speed,
	output logic fwd_out,
	output logic rev_out,
	output logic key_out,
	output logic [7:0] term_out,
	output logic [15:0] speed_out
);
	// Contacts start open so the drive sees defined levels from time zero.
	initial
	begin
		{fwd_out, rev_out, key_out, term_out, speed_out} = '0;
	end

	// Levels move just after an edge, like contacts unrelated to the
	// drive clock; any terminal may carry any function.
	always @(posedge clk)
	begin
		{fwd_out, rev_out, key_out} <= {want_fwd, want_rev, want_key};
		term_out <= want_term;
		speed_out <= want_speed;
	end
endmodule

// ===== testbench/test_oms_top.sv
// Self-checking bench for the operation mode switcher.
`timescale 1ns/1ns
module test_oms_top;
	logic CLK = 1'b0;
	logic RESETN;
	logic [7:0] TERM_IN;
	logic FWD_START_IN, REV_START_IN, PANEL_STOP_KEY;
	logic [15:0] EXT_SPEED_IN, SPEED_OUT, s1, s2;
	logic [31:0] S_AXI_AWADDR = '0, S_AXI_WDATA = '0, S_AXI_ARADDR = '0;
	logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
	logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
	logic S_AXI_RVALID, RUN_OUT;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, MODE_OUT, DIR_OUT;
	logic [31:0] S_AXI_RDATA;
	logic w_fwd = 0, w_rev = 0, w_key = 0;
	logic [7:0] w_term = '0;
	logic [15:0] w_spd = '0;
	int seed = 96803;
	int errors = 0;
	int n_compared = 0;

	oms_top i_oms_top (.CLK, .RESETN, .TERM_IN, .FWD_START_IN,
		.REV_START_IN, .EXT_SPEED_IN, .PANEL_STOP_KEY, .S_AXI_AWADDR,
		.S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB(4'hF),
		.S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
		.S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
		.S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
		.MODE_OUT, .RUN_OUT, .DIR_OUT, .SPEED_OUT);
	oms_far_end i_oms_far_end (.clk(CLK), .want_fwd(w_fwd),
		.want_rev(w_rev), .want_key(w_key), .want_term(w_term),
		.want_speed(w_spd), .fwd_out(FWD_START_IN), .rev_out(REV_START_IN),
		.key_out(PANEL_STOP_KEY), .term_out(TERM_IN),
		.speed_out(EXT_SPEED_IN));

	// Free-running drive clock.
	always #20 CLK = ~CLK;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] ctrl_word(input logic [3:0] sel);
		// Stop key enabled, interlock on terminal 0, switchover on 1.
		return (32'(sel) << oms_pkg::CTRL_MODE_LSB) |
			(32'h1 << oms_pkg::CTRL_STOPSEL_BIT) |
			(32'h1 << oms_pkg::CTRL_SWO_SEL_LSB);
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic settle();
		repeat (8) @(posedge CLK);
	endtask

	// Write address and data go out together; each drops when taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		S_AXI_AWADDR <= {24'h0, a};
		S_AXI_WDATA <= d;
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
		do
		begin
			@(posedge CLK);
			if (S_AXI_AWREADY)
				S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY)
				S_AXI_WVALID <= 1'b0;
		end while (!S_AXI_BVALID);
		S_AXI_BREADY <= 1'b0;
		chk(S_AXI_BRESP, oms_pkg::BRESP_OKAY);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		@(posedge CLK);
		S_AXI_ARADDR <= {24'h0, a};
		{S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
		do
		begin
			@(posedge CLK);
			if (S_AXI_ARREADY)
				S_AXI_ARVALID <= 1'b0;
		end while (!S_AXI_RVALID);
		S_AXI_RREADY <= 1'b0;
		chk(S_AXI_RDATA, d);
		chk(S_AXI_RRESP, r);
	endtask

	// A mode command is a one-bit pulse in the command register.
	task automatic cmd(input int bit_pos);
		wr(oms_pkg::ADDR_CMD, 32'h1 << bit_pos);
		settle();
	endtask

	// Unused terminals carry random levels to catch a wrong selection.
	task automatic pins(input logic f, r, ilk, swo, key);
		@(posedge CLK);
		{w_fwd, w_rev, w_key} <= {f, r, key};
		w_term <= {6'($random(seed)), swo, ilk};
		w_spd <= s2;
		settle();
	endtask

	task automatic tally_and_finish();
		$display("Compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	initial
	begin
		RESETN <= 1'b0;
		s2 = 16'($random(seed));
		s1 = s2;
		repeat (8) @(posedge CLK);
		RESETN <= 1'b1;
		pins(0, 0, 0, 0, 0);
		chk(MODE_OUT, 2'h0);
		rd(oms_pkg::ADDR_CTRL, ctrl_word(oms_pkg::MODE_SEL_RESET),
			oms_pkg::BRESP_OKAY);
		rd(8'h40, 32'h0, oms_pkg::BRESP_SLVERR);
		cmd(oms_pkg::CMD_TO_LINK_BIT);
		chk(MODE_OUT, 2'h2);
		chk(SPEED_OUT, s1);
		s2 = 16'($random(seed));
		pins(1, 0, 0, 0, 0);
		cmd(oms_pkg::CMD_TO_EXT_BIT);
		chk(MODE_OUT, 2'h0);
		chk(SPEED_OUT, s2);
		cmd(oms_pkg::CMD_TO_PANEL_BIT);
		chk(MODE_OUT, 2'h1);
		chk(DIR_OUT, 2'h2);
		cmd(oms_pkg::CMD_TO_LINK_BIT);
		chk(SPEED_OUT, s2);
		s1 = 16'($random(seed));
		wr(oms_pkg::ADDR_LINK_SPEED, {16'h0000, s1});
		settle();
		chk(SPEED_OUT, s1);
		cmd(oms_pkg::CMD_TO_PANEL_BIT);
		chk(SPEED_OUT, s1);
		cmd(oms_pkg::CMD_PANEL_STOP_BIT);
		chk(RUN_OUT, 1'b0);
		cmd(oms_pkg::CMD_PANEL_RUN_BIT);
		chk(RUN_OUT, 1'b1);
		chk(DIR_OUT, 2'h1);
		pins(0, 1, 0, 0, 0);
		cmd(oms_pkg::CMD_TO_EXT_BIT);
		chk(DIR_OUT, 2'h1);
		pins(0, 1, 0, 0, 1);
		chk(RUN_OUT, 1'b0);
		RESETN <= 1'b0;
		repeat (2) @(posedge CLK);
		chk(SPEED_OUT, 16'h0);
		RESETN <= 1'b1;
		pins(0, 0, 0, 0, 0);
		wr(oms_pkg::ADDR_CTRL, ctrl_word(oms_pkg::MODE_SEL_INTERLOCK));
		pins(1, 0, 1, 0, 0);
		chk(RUN_OUT, 1'b0);
		pins(1, 0, 0, 0, 0);
		chk(RUN_OUT, 1'b1);
		pins(0, 0, 1, 0, 0);
		cmd(oms_pkg::CMD_TO_PANEL_BIT);
		chk(MODE_OUT, 2'h0);
		cmd(oms_pkg::CMD_TO_LINK_BIT);
		cmd(oms_pkg::CMD_TO_PANEL_BIT);
		chk(MODE_OUT, 2'h1);
		pins(1, 0, 0, 0, 0);
		chk(MODE_OUT, 2'h0);
		chk(RUN_OUT, 1'b1);
		chk(SPEED_OUT, s2);
		pins(0, 0, 0, 0, 0);
		cmd(oms_pkg::CMD_TO_PANEL_BIT);
		chk(MODE_OUT, 2'h0);
		pins(0, 0, 1, 0, 0);
		cmd(oms_pkg::CMD_TO_LINK_BIT);
		pins(1, 0, 1, 0, 0);
		cmd(oms_pkg::CMD_TO_PANEL_BIT);
		chk(MODE_OUT, 2'h2);
		pins(0, 0, 1, 0, 0);
		wr(oms_pkg::ADDR_CTRL, ctrl_word(oms_pkg::MODE_SEL_SWITCHOVER));
		pins(0, 0, 0, 1, 0);
		chk(MODE_OUT, 2'h0);
		pins(0, 0, 0, 0, 0);
		chk(MODE_OUT, 2'h1);
		pins(0, 0, 0, 1, 0);
		pins(1, 0, 0, 1, 0);
		pins(1, 0, 0, 0, 0);
		chk(MODE_OUT, 2'h0);
		tally_and_finish();
	end

	// Watchdog well beyond the few hundred cycles the scenarios need.
	initial
	begin
		#200000;
		errors++;
		tally_and_finish();
	end
endmodule

bind oms_top oms_top_chk i_oms_top_chk (.CLK, .RESETN, .PANEL_STOP_KEY,
	.S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_BVALID, .S_AXI_BREADY,
	.S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY,
	.MODE_OUT, .RUN_OUT, .DIR_OUT, .SPEED_OUT);
